// >>> design/uctt_map.vh
// Register map, fields and reset values of the counter/timer block.
// Assumes an 8-bit register port with a 4-bit address.
`ifndef UCTT_MAP_VH
`define UCTT_MAP_VH

`define UCTT_ADDR_W 4
`define UCTT_DATA_W 8

// Write offsets
`define UCTT_OFF_CSR_A 4'h1
`define UCTT_OFF_CMD_A 4'h2
`define UCTT_OFF_AUX 4'h4
`define UCTT_OFF_MASK 4'h5
`define UCTT_OFF_PRE_HI 4'h6
`define UCTT_OFF_PRE_LO 4'h7
`define UCTT_OFF_CSR_B 4'h9
`define UCTT_OFF_CMD_B 4'ha

// Read offsets
`define UCTT_OFF_STATUS 4'h5
`define UCTT_OFF_CNT_HI 4'h6
`define UCTT_OFF_CNT_LO 4'h7
`define UCTT_OFF_START 4'he
`define UCTT_OFF_STOP 4'hf

// Fields
`define UCTT_READY_BIT 3
`define UCTT_AUX_TIMER_BIT 6
`define UCTT_AUX_SRC_HI 5
`define UCTT_AUX_SRC_LO 4
`define UCTT_CMD_HI 7
`define UCTT_CMD_LO 4
`define UCTT_CMD_TO_ON 4'ha
`define UCTT_CMD_TO_OFF 4'hc
`define UCTT_CSR_CT 4'hd

// Clock sources
`define UCTT_SRC_EXT 2'h0
`define UCTT_SRC_SYS 2'h1
`define UCTT_SRC_SYS16 2'h2
`define UCTT_SRC_EXT16 2'h3

// Reset values
`define UCTT_RST_BYTE 8'h00
`define UCTT_RST_CNT 16'h0000
`define UCTT_RST_DIV 4'h0

`endif

// >>> design/uctt_top.v
// Counter/timer with timer, counter and receive time-out modes.
// Assumes synchronous inputs and a host that never strobes rd and wr together.

`include "uctt_map.vh"
`timescale 1ns/1ps
`default_nettype none

module uctt_top (
  input wire clk,
  input wire rstn,
  input wire [3:0] addr,
  input wire [7:0] wdata,
  input wire wr,
  input wire rd,
  output reg [7:0] rdata,
  input wire ext_clk_in,
  input wire rx_load_a,
  input wire rx_load_b,
  input wire [7:0] other_irq,
  output reg ct_out,
  output reg [1:0] ct_rx_clk,
  output reg [1:0] ct_tx_clk,
  output reg interrupt_out_n
);

  // ==========================================================
  // Decode
  // ==========================================================
  function hit;
    input [3:0] a;
    input [3:0] off;
    begin
      hit = (a == off);
    end
  endfunction

  localparam [3:0] TO_IDLE = 4'b0001;
  localparam [3:0] TO_HOLD = 4'b0010;
  localparam [3:0] TO_WAIT = 4'b0100;
  localparam [3:0] TO_RUN = 4'b1000;

  reg [7:0] preset_low_byte;
  reg [7:0] preset_high_byte;
  reg [7:0] auxiliary_control_reg;
  reg [7:0] interrupt_mask_reg;
  reg [7:0] clock_select_a;
  reg [7:0] clock_select_b;
  reg to_en_a;
  reg to_en_b;
  reg [15:0] count;
  reg running;
  reg counter_ready_flag;
  reg [3:0] to_state;
  reg ext_q;
  reg [3:0] div;

  wire [15:0] preset = {preset_high_byte, preset_low_byte};
  wire [1:0] src = auxiliary_control_reg[`UCTT_AUX_SRC_HI:`UCTT_AUX_SRC_LO];
  wire timer_sel = auxiliary_control_reg[`UCTT_AUX_TIMER_BIT];
  wire to_mode = to_en_a | to_en_b;
  wire ext_rise = ext_clk_in & ~ext_q;

  wire wr_cmd_a = wr & hit(addr, `UCTT_OFF_CMD_A);
  wire wr_cmd_b = wr & hit(addr, `UCTT_OFF_CMD_B);
  wire [3:0] code = wdata[`UCTT_CMD_HI:`UCTT_CMD_LO];
  wire to_on = (wr_cmd_a | wr_cmd_b) & (code == `UCTT_CMD_TO_ON);
  wire start_cmd = rd & hit(addr, `UCTT_OFF_START) & ~to_mode;
  wire stop_cmd = rd & hit(addr, `UCTT_OFF_STOP) & ~to_mode;

  // Either enabled receiver restarts the one shared counter
  wire rx_event = (rx_load_a & to_en_a) | (rx_load_b & to_en_b);

  // ==========================================================
  // Tick source
  // ==========================================================
  // Prescaled sources divide by 16 to reach slow time-outs
  reg tick;
  always @* begin
    case (src)
      `UCTT_SRC_EXT: tick = ext_rise;
      `UCTT_SRC_SYS: tick = 1'b1;
      `UCTT_SRC_SYS16: tick = (div == 4'hf);
      `UCTT_SRC_EXT16: tick = ext_rise & (div == 4'hf);
      default: tick = 1'b0;
    endcase
  end

  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      ext_q <= 1'b0;
      div <= `UCTT_RST_DIV;
    end else begin
      ext_q <= ext_clk_in;
      if (src == `UCTT_SRC_SYS16 || (src == `UCTT_SRC_EXT16 && ext_rise)) begin
        div <= div + 4'h1;
      end
    end
  end

  // ==========================================================
  // Registers written by software
  // ==========================================================
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      preset_low_byte <= `UCTT_RST_BYTE;
      preset_high_byte <= `UCTT_RST_BYTE;
      auxiliary_control_reg <= `UCTT_RST_BYTE;
      interrupt_mask_reg <= `UCTT_RST_BYTE;
      clock_select_a <= `UCTT_RST_BYTE;
      clock_select_b <= `UCTT_RST_BYTE;
      to_en_a <= 1'b0;
      to_en_b <= 1'b0;
    end else begin
      if (wr && hit(addr, `UCTT_OFF_PRE_LO)) begin
        preset_low_byte <= wdata;
      end
      if (wr && hit(addr, `UCTT_OFF_PRE_HI)) begin
        preset_high_byte <= wdata;
      end
      if (wr && hit(addr, `UCTT_OFF_AUX)) begin
        auxiliary_control_reg <= wdata;
      end
      if (wr && hit(addr, `UCTT_OFF_MASK)) begin
        interrupt_mask_reg <= wdata;
      end
      if (wr && hit(addr, `UCTT_OFF_CSR_A)) begin
        clock_select_a <= wdata;
      end
      if (wr && hit(addr, `UCTT_OFF_CSR_B)) begin
        clock_select_b <= wdata;
      end
      if (wr_cmd_a && code == `UCTT_CMD_TO_ON) begin
        to_en_a <= 1'b1;
      end else if (wr_cmd_a && code == `UCTT_CMD_TO_OFF) begin
        to_en_a <= 1'b0;
      end
      if (wr_cmd_b && code == `UCTT_CMD_TO_ON) begin
        to_en_b <= 1'b1;
      end else if (wr_cmd_b && code == `UCTT_CMD_TO_OFF) begin
        to_en_b <= 1'b0;
      end
    end
  end

  // ==========================================================
  // Counter core
  // ==========================================================
  // Set paths come last so a timer-mode expiry beats a stop clear in the same cycle
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      count <= `UCTT_RST_CNT;
      running <= 1'b0;
      counter_ready_flag <= 1'b0;
      ct_out <= 1'b1;
      to_state <= TO_IDLE;
    end else if (to_mode || to_on) begin
      // The enable lands with this edge, so the on command itself must clear the flag and go to TO_IDLE
      if (to_on || rx_event) begin
        counter_ready_flag <= 1'b0;
      end
      if (rx_event) begin
        to_state <= TO_HOLD;
      end else if (to_on) begin
        to_state <= TO_IDLE;
      end else if (tick) begin
        case (to_state)
          TO_IDLE: to_state <= TO_IDLE;
          TO_HOLD: begin
            count <= preset;
            to_state <= TO_WAIT;
          end
          TO_WAIT: to_state <= TO_RUN;
          TO_RUN: begin
            count <= count - 16'h0001;
            if (count == 16'h0001) begin
              counter_ready_flag <= 1'b1;
              to_state <= TO_IDLE;
            end
          end
          default: to_state <= TO_IDLE;
        endcase
      end
      running <= 1'b0;
      ct_out <= 1'b1;
    end else begin
      to_state <= TO_IDLE;
      if (stop_cmd) begin
        counter_ready_flag <= 1'b0;
        if (!timer_sel) begin
          running <= 1'b0;
          ct_out <= 1'b1;
        end
      end
      if (start_cmd) begin
        count <= preset;
        running <= 1'b1;
        ct_out <= 1'b1;
      end else if (running && tick && timer_sel) begin
        // Timer keeps running through a stop command
        if (count <= 16'h0001) begin
          count <= preset;
          ct_out <= ~ct_out;
          if (ct_out) begin
            counter_ready_flag <= 1'b1;
          end
        end else begin
          count <= count - 16'h0001;
        end
      end else if (running && tick && !stop_cmd) begin
        count <= count - 16'h0001;
        if (count == 16'h0001 && ct_out) begin
          counter_ready_flag <= 1'b1;
          ct_out <= 1'b0;
        end
      end
    end
  end

  // ==========================================================
  // Channel clocks
  // ==========================================================
  wire [7:0] clock_select_reg [0:1];
  assign clock_select_reg[0] = clock_select_a;
  assign clock_select_reg[1] = clock_select_b;

  genvar ch;
  generate
    for (ch = 0; ch < 2; ch = ch + 1) begin : g_ch
      always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
          ct_rx_clk[ch] <= 1'b0;
          ct_tx_clk[ch] <= 1'b0;
        end else begin
          // Receiver and transmitter sample this as 16x clock
          ct_rx_clk[ch] <= (clock_select_reg[ch][7:4] == `UCTT_CSR_CT) & ct_out;
          ct_tx_clk[ch] <= (clock_select_reg[ch][3:0] == `UCTT_CSR_CT) & ct_out;
        end
      end
    end
  endgenerate

  // ==========================================================
  // Status, interrupt and read port
  // ==========================================================
  reg [7:0] status;
  always @* begin
    status = other_irq;
    status[`UCTT_READY_BIT] = counter_ready_flag;
  end

  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      interrupt_out_n <= 1'b1;
      rdata <= `UCTT_RST_BYTE;
    end else begin
      interrupt_out_n <= ~|(status & interrupt_mask_reg);
      if (rd && hit(addr, `UCTT_OFF_STATUS)) begin
        rdata <= status;
      end else if (rd && hit(addr, `UCTT_OFF_CNT_HI)) begin
        rdata <= count[15:8];
      end else if (rd && hit(addr, `UCTT_OFF_CNT_LO)) begin
        rdata <= count[7:0];
      end else begin
        rdata <= `UCTT_RST_BYTE;
      end
    end
  end

endmodule // uctt_top

`default_nettype wire

// >>> sim/uctt_props.sv
// Checker on the counter/timer top-level ports.
// Assumes one clock domain and the host keeping one strobe per cycle.
`timescale 1ns/1ps
`default_nettype none
module uctt_props (
  input wire logic clk,
  input wire logic rstn,
  input wire logic [3:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr,
  input wire logic rd,
  input wire logic [7:0] rdata,
  input wire logic [7:0] other_irq,
  input wire logic ct_out,
  input wire logic [1:0] ct_rx_clk,
  input wire logic [1:0] ct_tx_clk,
  input wire logic interrupt_out_n
);
  // =========
  // Mask shadow, so interrupt checks need no internals
  logic [7:0] mask;
  logic h1;
  logic h2;
  wire logic hit = |(other_irq & mask & 8'hf7);
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      mask <= 8'h00;
      h1 <= 1'b0;
      h2 <= 1'b0;
    end else begin
      if (wr && addr == 4'h5) mask <= wdata;
      h1 <= hit;
      h2 <= h1;
    end
  end
  // =========
  // Properties
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);
  a_rdata_idle: assert property (!$past(rd) |-> rdata == 8'h00)
    else $error("read data outside its cycle");
  a_unmapped_zero: assert property (rd && addr inside {[4'h0:4'h4], [4'h8:4'hd]}
    |=> rdata == 8'h00) else $error("unmapped read not zero");
  a_status_other: assert property (rd && addr == 4'h5 && $stable(other_irq)
    |=> {rdata[7:4], rdata[2:0]} == {$past(other_irq[7:4]), $past(other_irq[2:0])})
    else $error("status does not show other sources");
  a_rx_clk_src: assert property (|ct_rx_clk |-> $past(ct_out))
    else $error("receive clock without counter output");
  a_tx_clk_src: assert property (|ct_tx_clk |-> $past(ct_out))
    else $error("transmit clock without counter output");
  a_irq_other_on: assert property (hit && h1 && h2 |-> !interrupt_out_n)
    else $error("masked source gives no interrupt");
  a_irq_quiet: assert property (!hit && !h1 && !h2 && !mask[3] |-> interrupt_out_n)
    else $error("interrupt with no enabled cause");
  a_fall_irq: assert property ($fell(ct_out) && mask[3] |=> !interrupt_out_n)
    else $error("ready fall gave no interrupt");
  a_reset_state: assert property ($rose(rstn) |-> ct_out && interrupt_out_n)
    else $error("outputs wrong after reset");
  c_fall: cover property ($fell(ct_out));
  c_irq: cover property (!interrupt_out_n);
  c_status: cover property (rd && addr == 4'h5);
endmodule // uctt_props
bind uctt_top uctt_props i_props (.clk(clk), .rstn(rstn), .addr(addr), .wdata(wdata),
  .wr(wr), .rd(rd), .rdata(rdata), .other_irq(other_irq), .ct_out(ct_out),
  .ct_rx_clk(ct_rx_clk), .ct_tx_clk(ct_tx_clk), .interrupt_out_n(interrupt_out_n));
`default_nettype wire

// >>> sim/uctt_host.sv
// Host CPU model on the register port.
// Assumes the slave answers a read in the next cycle and never stalls.
`timescale 1ns/1ps
`default_nettype none
module uctt_host (
  input wire logic clk,
  output logic [3:0] addr,
  output logic [7:0] wdata,
  output logic wr,
  output logic rd,
  input wire logic [7:0] rdata
);
  // =========
  // Bus cycles; only whole divisors, timer counts never trusted
  initial begin
    addr = 4'h0;
    wdata = 8'h00;
    wr = 1'b0;
    rd = 1'b0;
  end
  task automatic wr_reg(input logic [3:0] a, input logic [7:0] v);
    @(posedge clk);
    addr <= a;
    wdata <= v;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
    #1;
  endtask
  task automatic rd_reg(input logic [3:0] a, output logic [7:0] v);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    v = rdata;
  endtask
endmodule // uctt_host
`default_nettype wire

// >>> sim/testbench.sv
// Self-checking bench for the counter/timer block.
// Assumes uctt_host drives the bus and uctt_props is bound to the top.
`timescale 1ns/1ps
`default_nettype none
module testbench;
  typedef struct packed {logic [7:0] aux; logic [15:0] pre; logic [15:0] n;} uctt_row_t;
  uctt_row_t rows [3] = '{'{8'h10, 16'h0003, 16'h0003}, '{8'h10, 16'h0105, 16'h0105},
    '{8'h50, 16'h0004, 16'h0004}};
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic ext_clk_in = 1'b0;
  logic rx_load_a = 1'b0;
  logic rx_load_b = 1'b0;
  logic [7:0] other_irq = 8'h00;
  logic [7:0] d;
  wire logic [3:0] addr;
  wire logic [7:0] wdata;
  wire logic wr;
  wire logic rd;
  wire logic [7:0] rdata;
  wire logic ct_out;
  wire logic [1:0] ct_rx_clk;
  wire logic [1:0] ct_tx_clk;
  wire logic interrupt_out_n;
  int failures = 0;
  int compares = 0;
  int cycles = 0;
  int n;
  always #50 clk = ~clk;
  always @(posedge clk) ext_clk_in <= ~ext_clk_in;
  uctt_host i_host (.clk(clk), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata));
  uctt_top i_dut (.clk(clk), .rstn(rstn), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .rdata(rdata), .ext_clk_in(ext_clk_in), .rx_load_a(rx_load_a), .rx_load_b(rx_load_b),
    .other_irq(other_irq), .ct_out(ct_out), .ct_rx_clk(ct_rx_clk), .ct_tx_clk(ct_tx_clk),
    .interrupt_out_n(interrupt_out_n));
  // =========
  // Helpers
  task automatic report_and_stop;
    $display("compares %0d failures %0d", compares, failures);
    if (failures == 0 && compares > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  always @(posedge clk) begin
    cycles = cycles + 1;
    if (cycles == 20000) begin
      failures = failures + 1;
      report_and_stop;
    end
  end
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    compares = compares + 1;
    if (seen !== exp) begin
      failures = failures + 1;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic rdc(input logic [3:0] a, input logic [7:0] e);
    i_host.rd_reg(a, d);
    chk({8'h00, d}, {8'h00, e});
  endtask
  task automatic wait_lvl(input logic v);
    n = 0;
    while (ct_out !== v && n < 400) begin
      @(posedge clk);
      #1;
      n = n + 1;
    end
  endtask
  task automatic rx(input logic b);
    @(posedge clk);
    rx_load_a <= !b;
    rx_load_b <= b;
    @(posedge clk);
    rx_load_a <= 1'b0;
    rx_load_b <= 1'b0;
    #1;
  endtask
  // =========
  // Main sequence
  initial begin
    repeat (20) @(posedge clk);
    rstn <= 1'b1;
    #1;
    chk({14'h0000, ct_out, interrupt_out_n}, 16'h0003);
    rdc(4'h6, 8'h00);
    rdc(4'h7, 8'h00);
    rdc(4'h3, 8'h00);
    other_irq <= 8'h05;
    rdc(4'h5, 8'h05);
    other_irq <= 8'h00;
    i_host.wr_reg(4'h5, 8'h08);
    i_host.wr_reg(4'h1, 8'hdd);
    foreach (rows[i]) begin
      i_host.wr_reg(4'h4, rows[i].aux);
      i_host.wr_reg(4'h6, rows[i].pre[15:8]);
      i_host.wr_reg(4'h7, rows[i].pre[7:0]);
      i_host.rd_reg(4'he, d);
      wait_lvl(1'b0);
      chk(n[15:0], rows[i].n);
      if (rows[i].aux[6]) begin
        wait_lvl(1'b1);
        chk(n[15:0], rows[i].n);
        @(posedge clk);
        #1;
        chk({12'h000, ct_rx_clk, ct_tx_clk}, 16'h0005);
      end
      rdc(4'h5, 8'h08);
      if (!rows[i].aux[6]) begin
        rdc(4'h6, 8'hff);
        chk({15'h0000, ct_out}, 16'h0000);
      end
      i_host.rd_reg(4'hf, d);
      rdc(4'h5, 8'h00);
      if (rows[i].aux[6]) begin
        wait_lvl(1'b1);
        wait_lvl(1'b0);
        rdc(4'h5, 8'h08);
      end
    end
    // Time-out on channel A; preset 6
    i_host.wr_reg(4'h6, 8'h00);
    i_host.wr_reg(4'h7, 8'h06);
    i_host.wr_reg(4'h2, 8'ha0);
    rdc(4'h5, 8'h00);
    repeat (10) @(posedge clk);
    rdc(4'h5, 8'h00);
    rx(1'b0);
    repeat (4) @(posedge clk);
    rx(1'b0);
    repeat (3) @(posedge clk);
    rdc(4'h5, 8'h00);
    repeat (10) @(posedge clk);
    rdc(4'h5, 8'h08);
    chk({15'h0000, interrupt_out_n}, 16'h0000);
    i_host.rd_reg(4'hf, d);
    rdc(4'h5, 8'h08);
    rx(1'b0);
    rdc(4'h5, 8'h00);
    chk({15'h0000, interrupt_out_n}, 16'h0001);
    // Both channels on
    i_host.wr_reg(4'ha, 8'ha0);
    rx(1'b1);
    repeat (4) @(posedge clk);
    rx(1'b0);
    repeat (3) @(posedge clk);
    rdc(4'h5, 8'h00);
    repeat (10) @(posedge clk);
    rdc(4'h5, 8'h08);
    i_host.wr_reg(4'h2, 8'hc0);
    i_host.wr_reg(4'ha, 8'hc0);
    i_host.rd_reg(4'hf, d);
    rdc(4'h5, 8'h00);
    report_and_stop;
  end
endmodule // testbench
`default_nettype wire
